// ---- logic/fcs_flash_ctrl.sv ----
// AXI4-Lite register block for flash mode, error status, erase block select, power and access gating
//
// Added by the designer: the register addresses and the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
`default_nettype none
module fcs_flash_ctrl
    import fcs_pkg::*;
(
    input  wire logic                    aclk,
    input  wire logic                    aresetn,
    input  wire logic [FCS_ADDR_W-1:0]   s_axi_awaddr,
    input  wire logic [2:0]              s_axi_awprot,
    input  wire logic                    s_axi_awvalid,
    output logic                         s_axi_awready,
    input  wire logic [31:0]             s_axi_wdata,
    input  wire logic [3:0]              s_axi_wstrb,
    input  wire logic                    s_axi_wvalid,
    output logic                         s_axi_wready,
    output logic [1:0]                   s_axi_bresp,
    output logic                         s_axi_bvalid,
    input  wire logic                    s_axi_bready,
    input  wire logic [FCS_ADDR_W-1:0]   s_axi_araddr,
    input  wire logic [2:0]              s_axi_arprot,
    input  wire logic                    s_axi_arvalid,
    output logic                         s_axi_arready,
    output logic [31:0]                  s_axi_rdata,
    output logic [1:0]                   s_axi_rresp,
    output logic                         s_axi_rvalid,
    input  wire logic                    s_axi_rready,
    input  wire logic                    flash_fault,
    input  wire logic                    subactive_mode,
    output logic                         error_protect,
    output logic                         flash_powerdown,
    output logic [7:0]                   flash_mode_out,
    output logic [FCS_NUM_BLOCKS-1:0]    erase_block_out
);

    typedef enum logic [1:0] {
        FCS_W_IDLE,
        FCS_W_RESP
    } fcs_wstate_t;

    fcs_wstate_t                wstate;
    logic                       aw_held;
    logic                       w_held;
    logic [FCS_ADDR_W-1:0]      aw_addr;
    logic [31:0]                w_data;
    logic [7:0]                 flash_mode_control;
    logic                       flash_error_flag;
    logic [6:0]                 erase_block_select;
    logic                       powerdown_disable;
    logic                       ctrl_reg_access_en;
    logic                       fault_s1;
    logic                       fault_s2;
    logic                       fault_s3;
    logic                       sub_s1;
    logic                       sub_s2;
    logic                       sub_s3;
    logic                       fault_lvl;
    logic                       sub_lvl;
    logic                       fault_prev;
    logic                       do_write;
    logic                       wr_known;
    logic                       wr_mode_sel;
    logic                       wr_erase_sel;
    logic                       wr_power_sel;
    logic                       wr_access_sel;
    logic                       wr_ctrl_sel;
    logic                       fault_rise;
    logic                       prog_or_erase;
    logic                       rd_known;
    logic                       rd_gated;
    logic [31:0]                next_rdata;
    logic [7:0]                 next_mode;
    logic [6:0]                 next_erase;

    // Register classes reused by both the read and the write path
    function automatic logic fcs_is_gated(input logic [FCS_ADDR_W-1:0] a);
        if (a == FCS_OFF_MODE || a == FCS_OFF_STATUS) begin
            return 1'b1;
        end else if (a == FCS_OFF_ERASE_SEL || a == FCS_OFF_POWER) begin
            return 1'b1;
        end else begin
            return 1'b0;
        end
    endfunction

    function automatic logic fcs_is_known(input logic [FCS_ADDR_W-1:0] a);
        if (fcs_is_gated(a)) begin
            return 1'b1;
        end else if (a == FCS_OFF_ACCESS_EN || a == FCS_OFF_CTRL) begin
            return 1'b1;
        end else begin
            return 1'b0;
        end
    endfunction

    // Several selector bits at once; such a write clears the whole selector
    function automatic logic fcs_multi_hot(input logic [FCS_NUM_BLOCKS-1:0] v);
        logic seen;
        logic multi;
        seen  = 1'b0;
        multi = 1'b0;
        for (int i = 0; i < FCS_NUM_BLOCKS; i++) begin
            if (v[i]) begin
                multi = multi | seen;
                seen  = 1'b1;
            end
        end
        return multi;
    endfunction

    // Pin inputs: three stages, a change counts once stages two and three agree
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            fault_s1  <= 1'b0;
            fault_s2  <= 1'b0;
            fault_s3  <= 1'b0;
            sub_s1    <= 1'b0;
            sub_s2    <= 1'b0;
            sub_s3    <= 1'b0;
            fault_lvl <= 1'b0;
            sub_lvl   <= 1'b0;
        end else begin
            fault_s1 <= flash_fault;
            fault_s2 <= fault_s1;
            fault_s3 <= fault_s2;
            sub_s1   <= subactive_mode;
            sub_s2   <= sub_s1;
            sub_s3   <= sub_s2;
            if (fault_s2 == fault_s3) begin
                fault_lvl <= fault_s3;
            end
            if (sub_s2 == sub_s3) begin
                sub_lvl <= sub_s3;
            end
        end
    end

    // Write channel: address and data taken in either order, response after both
    assign do_write = aw_held && w_held && (wstate == FCS_W_IDLE);
    assign wr_known = fcs_is_known(aw_addr);

    // One strobe per register; status is left out, so a write to it is dropped
    always_comb begin
        wr_mode_sel   = 1'b0;
        wr_erase_sel  = 1'b0;
        wr_power_sel  = 1'b0;
        wr_access_sel = 1'b0;
        wr_ctrl_sel   = 1'b0;
        if (do_write && aw_addr == FCS_OFF_ACCESS_EN) begin
            wr_access_sel = 1'b1;
        end else if (do_write && aw_addr == FCS_OFF_CTRL) begin
            wr_ctrl_sel = 1'b1;
        end else if (do_write && ctrl_reg_access_en) begin           // [RULE14] [RULE18]
            if (aw_addr == FCS_OFF_MODE) begin
                wr_mode_sel = 1'b1;
            end else if (aw_addr == FCS_OFF_ERASE_SEL) begin
                wr_erase_sel = 1'b1;
            end else if (aw_addr == FCS_OFF_POWER) begin
                wr_power_sel = 1'b1;
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            wstate        <= FCS_W_IDLE;
            aw_held       <= 1'b0;
            w_held        <= 1'b0;
            aw_addr       <= '0;
            w_data        <= '0;
            s_axi_awready <= 1'b0;
            s_axi_wready  <= 1'b0;
            s_axi_bvalid  <= 1'b0;
            s_axi_bresp   <= FCS_RESP_OKAY;
        end else begin
            s_axi_awready <= 1'b0;
            s_axi_wready  <= 1'b0;
            case (wstate)
                FCS_W_IDLE: begin
                    if (s_axi_awvalid && !aw_held && !s_axi_awready) begin
                        s_axi_awready <= 1'b1;
                        aw_held       <= 1'b1;
                        aw_addr       <= s_axi_awaddr;
                    end
                    if (s_axi_wvalid && !w_held && !s_axi_wready) begin
                        s_axi_wready <= 1'b1;
                        w_held       <= 1'b1;
                        w_data       <= s_axi_wstrb[0] ? s_axi_wdata : 32'h0000_0000;
                    end
                    if (do_write) begin
                        s_axi_bvalid <= 1'b1;
                        s_axi_bresp  <= wr_known ? FCS_RESP_OKAY : FCS_RESP_SLVERR;
                        wstate       <= FCS_W_RESP;
                    end
                end
                FCS_W_RESP: begin
                    if (s_axi_bready) begin
                        s_axi_bvalid <= 1'b0;
                        aw_held      <= 1'b0;
                        w_held       <= 1'b0;
                        wstate       <= FCS_W_IDLE;
                    end
                end
                default: begin
                    wstate <= FCS_W_IDLE;
                end
            endcase
        end
    end

    // Never gated itself, or a closed block could not be reopened
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ctrl_reg_access_en <= 1'b0;
        end else if (wr_access_sel) begin                            // [RULE17]
            ctrl_reg_access_en <= w_data[FCS_BIT_ACCESS_EN];         // [RULE14] [RULE15]
        end
    end

    // Mode register; clearing write enable drops every mode bit with it
    always_comb begin
        next_mode = flash_mode_control;
        if (wr_mode_sel) begin                                        // [RULE18]
            if (w_data[FCS_BIT_SWE]) begin
                next_mode = w_data[7:0] & FCS_MODE_WMASK;             // [RULE4]
            end else begin
                next_mode = FCS_RST_MODE;                             // [RULE16]
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            flash_mode_control <= FCS_RST_MODE;
        end else begin
            flash_mode_control <= next_mode;
        end
    end

    // Selector write, before the multi-bit and write-enable checks
    always_comb begin
        next_erase = erase_block_select;
        if (wr_erase_sel) begin                                       // [RULE14]
            next_erase = w_data[6:0];
        end
    end

    // Write enable is taken from the stored mode bit, so the clear lands a cycle after it drops
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            erase_block_select <= FCS_RST_ERASE_SEL;
        end else if (!flash_mode_control[FCS_BIT_SWE]) begin
            erase_block_select <= FCS_RST_ERASE_SEL;                  // [RULE5] [RULE16]
        end else if (fcs_multi_hot(next_erase)) begin
            erase_block_select <= FCS_RST_ERASE_SEL;                  // [RULE6]
        end else begin
            erase_block_select <= next_erase;                         // [RULE7] [RULE8] [RULE9] [RULE10]
        end
    end

    // A fault only counts while program (bit 0) or erase (bit 1) is running
    assign prog_or_erase = (flash_mode_control[1:0] != 2'h0);
    assign fault_rise    = fault_lvl && !fault_prev;

    // Error flag: hardware set wins over a software clear in the same cycle
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            fault_prev       <= 1'b0;
            flash_error_flag <= 1'b0;
        end else begin
            fault_prev <= fault_lvl;
            if (fault_rise && prog_or_erase) begin
                flash_error_flag <= 1'b1;                             // [RULE1]
            end else if (wr_ctrl_sel && w_data[FCS_BIT_ERR_CLEAR]) begin
                flash_error_flag <= 1'b0;
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            powerdown_disable <= 1'b0;
        end else if (wr_power_sel) begin                             // [RULE18]
            powerdown_disable <= w_data[FCS_BIT_PDWN_DIS];
        end
    end

    // Outputs to the array; power-down only trims the supply, reads stay open
    // Error protection masks only the array side; the registers keep their values
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            error_protect   <= 1'b0;
            flash_powerdown <= 1'b0;
            flash_mode_out  <= 8'h00;
            erase_block_out <= '0;
        end else begin
            error_protect   <= flash_error_flag;                      // [RULE2]
            flash_powerdown <= sub_lvl && !powerdown_disable;         // [RULE11] [RULE12] [RULE13]
            flash_mode_out  <= flash_error_flag ? 8'h00 : flash_mode_control;  // [RULE2]
            erase_block_out <= flash_error_flag ? '0 : erase_block_select;
        end
    end

    // Read path: status writes are dropped by leaving it out of the write decode
    // Read data is captured with arready and held, so a pending answer never changes
    assign rd_known = fcs_is_known(s_axi_araddr);
    assign rd_gated = fcs_is_gated(s_axi_araddr);

    always_comb begin
        next_rdata = 32'h0000_0000;
        if (rd_gated && !ctrl_reg_access_en) begin
            next_rdata = 32'h0000_0000;                               // [RULE15] [RULE18]
        end else if (s_axi_araddr == FCS_OFF_MODE) begin
            next_rdata[7:0] = flash_mode_control;
        end else if (s_axi_araddr == FCS_OFF_STATUS) begin
            next_rdata[FCS_BIT_ERR_FLAG] = flash_error_flag;          // [RULE1] [RULE3] [RULE4]
        end else if (s_axi_araddr == FCS_OFF_ERASE_SEL) begin
            next_rdata[6:0] = erase_block_select;                     // [RULE4]
        end else if (s_axi_araddr == FCS_OFF_POWER) begin
            next_rdata[FCS_BIT_PDWN_DIS] = powerdown_disable;         // [RULE4]
        end else if (s_axi_araddr == FCS_OFF_ACCESS_EN) begin
            next_rdata[FCS_BIT_ACCESS_EN] = ctrl_reg_access_en;       // [RULE17]
        end else if (s_axi_araddr == FCS_OFF_CTRL) begin
            next_rdata[FCS_BIT_SUBACTIVE] = sub_lvl;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b0;
            s_axi_rdata   <= 32'h0000_0000;
            s_axi_rresp   <= FCS_RESP_OKAY;
        end else begin
            s_axi_arready <= 1'b0;
            if (s_axi_rvalid) begin
                if (s_axi_rready) begin
                    s_axi_rvalid <= 1'b0;
                end
            end else if (s_axi_arvalid && !s_axi_arready) begin
                s_axi_arready <= 1'b1;
                s_axi_rvalid  <= 1'b1;
                s_axi_rdata   <= next_rdata;
                s_axi_rresp   <= rd_known ? FCS_RESP_OKAY : FCS_RESP_SLVERR;
            end
        end
    end

endmodule
`default_nettype wire

// ---- logic/fcs_pkg.sv ----
// Package with register map, field positions and reset values of the flash control status block
//
// Functional notes
// RULE1: Error flag, status bit 7, sets when programming or erasing reports a fault.
// RULE2: While the error flag is 1 the array is held in error protection.
// RULE3: Software never writes the status register; it is read-only.
// RULE4: Reserved bits read 0: bits 6..0 of three registers, selector bit 7.
// RULE5: Erase selector is forced to zero while software write enable is 0.
// RULE6: A write leaving several selector bits set clears the whole selector.
// RULE7: Selector bits 0..3 pick four 1 kbyte blocks from 0x0000 to 0x0FFF.
// RULE8: Selector bit 4 picks the 28 kbyte block 0x1000 to 0x7FFF.
// RULE9: Selector bit 5 picks the block 0x8000 to 0xBFFF.
// RULE10: Selector bit 6 picks the block 0xC000 to 0xDFFF.
// RULE11: Power-down disable 0 and subactive entry put flash in power-down.
// RULE12: Power-down disable 1 keeps flash in normal mode during subactive.
// RULE13: Power-down partly halts the supply circuit; reading stays possible.
// RULE14: Access enable bit 7 at 1 opens the four flash control registers.
// RULE15: Access enable 0 blocks CPU access to those four registers.
// RULE16: Mode register write enable bit 6 gates all programming, erasing and selector bits.
// RULE17: The access enable register stays reachable at all times.
// RULE18: Gated registers read zero and ignore writes while access is closed.
package fcs_pkg;
    localparam int          FCS_ADDR_W          = 8;
    localparam logic [7:0]  FCS_OFF_MODE        = 8'h00;
    localparam logic [7:0]  FCS_OFF_STATUS      = 8'h04;
    localparam logic [7:0]  FCS_OFF_ERASE_SEL   = 8'h08;
    localparam logic [7:0]  FCS_OFF_POWER       = 8'h0C;
    localparam logic [7:0]  FCS_OFF_ACCESS_EN   = 8'h10;
    localparam logic [7:0]  FCS_OFF_CTRL        = 8'h14;

    localparam int          FCS_BIT_ERR_FLAG    = 7;
    localparam int          FCS_BIT_SWE         = 6;
    localparam int          FCS_BIT_PDWN_DIS    = 7;
    localparam int          FCS_BIT_ACCESS_EN   = 7;
    localparam int          FCS_BIT_SUBACTIVE   = 0;
    localparam int          FCS_BIT_ERR_CLEAR   = 1;
    localparam int          FCS_NUM_BLOCKS      = 7;

    localparam logic [7:0]  FCS_RST_MODE        = 8'h00;
    localparam logic [6:0]  FCS_RST_ERASE_SEL   = 7'h00;
    localparam logic [7:0]  FCS_MODE_WMASK      = 8'h7F;

    localparam logic [1:0]  FCS_RESP_OKAY       = 2'h0;
    localparam logic [1:0]  FCS_RESP_SLVERR     = 2'h2;

    // Base and last byte address of each erase block, bit order of the selector
    localparam logic [15:0] FCS_BLK_BASE [FCS_NUM_BLOCKS] = '{16'h0000, 16'h0400, 16'h0800,
                                                            16'h0C00, 16'h1000, 16'h8000, 16'hC000};
    localparam logic [15:0] FCS_BLK_LAST [FCS_NUM_BLOCKS] = '{16'h03FF, 16'h07FF, 16'h0BFF,
                                                            16'h0FFF, 16'h7FFF, 16'hBFFF, 16'hDFFF};
endpackage

// ---- dv/fcs_flash_ctrl_chk.sv ----
// Port-level assertions for the flash control register block
`timescale 1ns/1ps
`default_nettype none
module fcs_flash_ctrl_chk
    import fcs_pkg::*;
(
    input wire logic                      aclk,
    input wire logic                      aresetn,
    input wire logic                      s_axi_awready,
    input wire logic                      s_axi_wready,
    input wire logic                      s_axi_bvalid,
    input wire logic                      s_axi_bready,
    input wire logic                      s_axi_arready,
    input wire logic                      s_axi_rvalid,
    input wire logic                      s_axi_rready,
    input wire logic [31:0]               s_axi_rdata,
    input wire logic                      subactive_mode,
    input wire logic                      error_protect,
    input wire logic                      flash_powerdown,
    input wire logic [7:0]                flash_mode_out,
    input wire logic [FCS_NUM_BLOCKS-1:0] erase_block_out
);
    default clocking @(posedge aclk); endclocking
    default disable iff (!aresetn);
    a_bvalid_holds:
        assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid) else $error("bvalid dropped early");
    a_rdata_stable:
        assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
            else $error("read answer changed while pending");
    a_awready_pulse:
        assert property (s_axi_awready |=> !s_axi_awready) else $error("awready longer than one cycle");
    a_read_answer:
        assert property (s_axi_arready |-> s_axi_rvalid) else $error("rvalid missing with arready");
    a_resp_after_addr:
        assert property ($rose(s_axi_bvalid) |-> $past(s_axi_awready) || $past(s_axi_wready))
            else $error("bvalid without address");
    a_sel_one_hot:
        assert property ($onehot0(erase_block_out)) else $error("several erase blocks selected");
    a_err_blocks_mode:
        assert property (error_protect |-> flash_mode_out == 8'h00 && erase_block_out == '0)
            else $error("mode active while error protected");
    a_swe_clears_sel:
        assert property (!flash_mode_out[FCS_BIT_SWE] && !error_protect |=> erase_block_out == '0)
            else $error("selector kept without write enable");
    a_awake_no_pdwn:
        assert property ((!subactive_mode)[*6] |=> !flash_powerdown) else $error("power-down outside subactive");
endmodule
bind fcs_flash_ctrl fcs_flash_ctrl_chk u_chk (.aclk(aclk), .aresetn(aresetn), .s_axi_awready(s_axi_awready),
    .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_arready(s_axi_arready),
    .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .s_axi_rdata(s_axi_rdata),
    .subactive_mode(subactive_mode), .error_protect(error_protect), .flash_powerdown(flash_powerdown),
    .flash_mode_out(flash_mode_out), .erase_block_out(erase_block_out), .s_axi_wready(s_axi_wready));
`default_nettype wire

// ---- dv/tb_fcs_flash_ctrl.sv ----
// Self-checking bench for the flash control register block over AXI4-Lite
`timescale 1ns/1ps
`default_nettype none
module tb_fcs_flash_ctrl;
    import fcs_pkg::*;
    logic                      aclk = 1'b0;
    logic                      aresetn = 1'b0;
    logic [7:0]                awaddr = 8'h00;
    logic [7:0]                araddr = 8'h00;
    logic [31:0]               wdata = 32'h0;
    logic                      awvalid = 1'b0;
    logic                      wvalid = 1'b0;
    logic                      bready = 1'b0;
    logic                      arvalid = 1'b0;
    logic                      rready = 1'b0;
    logic                      flash_fault = 1'b0;
    logic                      subactive_mode = 1'b0;
    logic                      awready, wready, bvalid, arready, rvalid;
    logic [1:0]                bresp, rresp;
    logic [31:0]               rdata;
    logic                      error_protect, flash_powerdown;
    logic [7:0]                flash_mode_out;
    logic [FCS_NUM_BLOCKS-1:0] erase_block_out;
    int                        n_errors = 0;
    int                        comparisons = 0;

    fcs_flash_ctrl u_fcs_flash_ctrl (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awprot(3'h0),
        .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hF),
        .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
        .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arprot(3'h0), .s_axi_arvalid(arvalid),
        .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
        .s_axi_rready(rready), .flash_fault(flash_fault), .subactive_mode(subactive_mode),
        .error_protect(error_protect), .flash_powerdown(flash_powerdown), .flash_mode_out(flash_mode_out),
        .erase_block_out(erase_block_out));

    always #5 aclk = ~aclk;

    task automatic summarize();
        if (n_errors == 0 && comparisons > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    task automatic chk(input logic [33:0] got, input logic [33:0] exp);
        comparisons++;
        if (got !== exp) begin
            n_errors++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    // Address and data offered together, each released when taken
    task automatic wr(input logic [7:0] a, input logic [7:0] d, input logic [1:0] er = FCS_RESP_OKAY);
        @(posedge aclk);
        awaddr <= a;
        wdata <= {24'h0, d};
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        for (int t = 0; t < 50; t++) begin
            @(posedge aclk);
            if (awready === 1'b1) awvalid <= 1'b0;
            if (wready === 1'b1) wvalid <= 1'b0;
            if (bvalid === 1'b1) break;
        end
        bready <= 1'b0;
        chk({bresp, 31'h0, bvalid}, {er, 31'h0, 1'b1});
    endtask

    task automatic rd(input logic [7:0] a, input logic [7:0] exp, input logic [1:0] er = FCS_RESP_OKAY);
        @(posedge aclk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        for (int t = 0; t < 50; t++) begin
            @(posedge aclk);
            if (arready === 1'b1) arvalid <= 1'b0;
            if (rvalid === 1'b1) break;
        end
        rready <= 1'b0;
        chk({33'h0, rvalid}, 34'h1);
        if (er == FCS_RESP_OKAY) chk({rresp, rdata}, {er, 24'h0, exp});
        else chk({rresp, 32'h0}, {er, 32'h0});
    endtask

    // Pins are synchronised inside, so wait a bounded time for the output
    task automatic wait_pin(input int k, input logic v);
        for (int t = 0; t < 20; t++) begin
            @(posedge aclk);
            if ((k == 0 ? error_protect : flash_powerdown) === v) break;
        end
        chk({33'h0, (k == 0 ? error_protect : flash_powerdown)}, {33'h0, v});
    endtask

    initial begin
        #200000;
        n_errors++;
        summarize();
    end

    initial begin
        repeat (12) @(posedge aclk);
        aresetn <= 1'b1;
        rd(FCS_OFF_ACCESS_EN, 8'h00);
        wr(FCS_OFF_POWER, 8'h80);
        wr(FCS_OFF_ACCESS_EN, 8'hFF);
        rd(FCS_OFF_ACCESS_EN, 8'h80);
        rd(FCS_OFF_POWER, 8'h00);
        wr(FCS_OFF_POWER, 8'hFF);
        rd(FCS_OFF_POWER, 8'h80);
        subactive_mode <= 1'b1;
        repeat (8) @(posedge aclk);
        chk({33'h0, flash_powerdown}, 34'h0);
        wr(FCS_OFF_POWER, 8'h00);
        wait_pin(1, 1'b1);
        rd(FCS_OFF_POWER, 8'h00);
        subactive_mode <= 1'b0;
        wait_pin(1, 1'b0);
        wr(FCS_OFF_ERASE_SEL, 8'h01);
        rd(FCS_OFF_ERASE_SEL, 8'h00);
        wr(FCS_OFF_MODE, 8'h40);
        for (int i = 0; i < FCS_NUM_BLOCKS; i++) begin
            wr(FCS_OFF_ERASE_SEL, 8'h01 << i);
            rd(FCS_OFF_ERASE_SEL, 8'h01 << i);
            chk({27'h0, erase_block_out}, {26'h0, 8'h01 << i});
        end
        chk({26'h0, flash_mode_out}, {26'h0, 8'h40});
        wr(FCS_OFF_ERASE_SEL, 8'h03);
        rd(FCS_OFF_ERASE_SEL, 8'h00);
        wr(FCS_OFF_ERASE_SEL, 8'h10);
        wr(FCS_OFF_MODE, 8'h00);
        rd(FCS_OFF_ERASE_SEL, 8'h00);
        rd(FCS_OFF_STATUS, 8'h00);
        rd(FCS_OFF_STATUS, 8'h00);
        wr(FCS_OFF_MODE, 8'h41);
        flash_fault <= 1'b1;
        wait_pin(0, 1'b1);
        rd(FCS_OFF_STATUS, 8'h80);
        chk({26'h0, flash_mode_out}, 34'h0);
        flash_fault <= 1'b0;
        wr(FCS_OFF_CTRL, 8'h02);
        wait_pin(0, 1'b0);
        wr(8'h20, 8'h55, FCS_RESP_SLVERR);
        rd(8'h20, 8'h00, FCS_RESP_SLVERR);
        wr(FCS_OFF_ACCESS_EN, 8'h00);
        wr(FCS_OFF_MODE, 8'h40);
        rd(FCS_OFF_MODE, 8'h00);
        wr(FCS_OFF_ACCESS_EN, 8'h80);
        rd(FCS_OFF_MODE, 8'h41);
        summarize();
    end
endmodule
`default_nettype wire
